// ---- bench/engine_stop_limit_status_msgs_test.sv ----
/* self-checking bench; assumes esl_core and esl_node */
`timescale 1ns/10ps
`default_nettype none
module engine_stop_limit_status_msgs_test;
  import esl_pkg::*;
  logic mclk_i = 0, sys_rst_i = 1, go = 0, ign = 1, ard = 0;
  logic eng = 0, own = 1, oth = 0, rsv = 0, a3p = 1;
  logic [7:0] src = 0, b1 = 0, b2 = 0, mp = 0, sp_s = 0, tq = 0, pw = 0, d1 = 8'hA5;
  logic [7:0] la = 8'h00, lar = 8'h00, rsn = 8'h00;
  logic [3:0][15:0] ain = {16'hFFFF, 16'h0000, 16'h09C4, 16'h0000};
  // map, speed, torque, power, flags, gates; then power, torque, speed, map, byte 1 expected
  logic [7:0] rows [3][11] = '{
    '{8'h03, 8'h06, 8'h0D, 8'h14, 8'h81, 8'h01, 8'h14, 8'h0D, 8'h06, 8'h03, 8'h01},
    '{8'h07, 8'h01, 8'h0F, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h0F, 8'h01, 8'h07, 8'hFF},
    '{8'h08, 8'h07, 8'h10, 8'h15, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}};
  wire logic rxv;
  wire logic [7:0] rxs;
  wire logic [63:0] rxd;
  logic sc, sp, sl, cc;
  logic [7:0] lt, fc;
  logic [63:0] lp, ip;
  int mismatches = 0, n_checks = 0, cyc = 0;
  always #12.5 mclk_i = ~mclk_i;
  esl_node node (.clk_i(mclk_i), .go_i(go), .src_i(src), .stop_i(b1), .lock_i(b2),
    .valid_o(rxv), .src_o(rxs), .data_o(rxd));
  esl_core dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .rx_valid_i(rxv), .rx_src_addr_i(rxs),
    .rx_data_i(rxd), .engine_running_i(eng), .ignition_on_i(ign), .afterrun_done_i(ard),
    .starter_owned_i(own), .other_lock_i(oth), .fuel_demand_i(8'h40), .crank_demand_i(1'b1),
    .lim1_active_i(la), .lim1_armed_i(lar), .lim2_active_i(4'h9), .torque_map_i(mp),
    .speed_src_i(sp_s), .torque_src_i(tq), .power_src_i(pw), .stop_reason_i(rsn),
    .stop_reason_valid_i(rsv), .din1_i(d1), .din2_i(5'h16), .ain3_present_i(a3p),
    .ain_mv_i(ain), .pulse_rpm_i(16'd500), .stop_cmd_o(sc), .start_prevent_o(sp),
    .start_lock_o(sl), .lock_table_o(lt), .fuel_cmd_o(fc), .crank_cmd_o(cc),
    .lim_payload_o(lp), .inp_payload_o(ip));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [7:0] s, input logic [7:0] v1, input logic [7:0] v2);
    src = s;
    b1 = v1;
    b2 = v2;
    go = 1;
    @(negedge mclk_i);
    go = 0;
    repeat (2) @(negedge mclk_i);
  endtask : send
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // run guard
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      mismatches++;
      summarize();
    end
  end
  // main sequence
  initial
  begin
    repeat (10) @(negedge mclk_i);
    chk(lp, 64'h0);
    chk(ip, 64'h0);
    sys_rst_i = 0;
    foreach (rows[i])
    begin
      {mp, sp_s, tq, pw, la, lar} = {rows[i][0], rows[i][1], rows[i][2], rows[i][3],
                                     rows[i][4], rows[i][5]};
      repeat (2) @(negedge mclk_i);
      chk(lp[47:40], rows[i][6]);
      chk(lp[39:32], rows[i][7]);
      chk(lp[31:24], rows[i][8]);
      chk(lp[23:16], rows[i][9]);
      chk(lp[7:0], rows[i][10]);
    end
    chk({ip[63:48], ip[15:0]}, {16'd100, 16'h16A5});
    chk(ip[47:16], {8'hFF, 8'h00, 8'h32, 8'h00});
    a3p = 0;
    @(negedge mclk_i);
    chk(ip[23:16], 8'hFF);
    a3p = 1;
    chk({lp[15:0], fc, cc}, {8'h24, 8'h00, 8'h40, 1'b1});
    eng = 1;
    send(8'h07, 8'h01, 8'hFF);
    chk({sc, sp, lt, fc, cc}, {2'b10, 8'h00, 8'h00, 1'b0});
    eng = 0;
    send(8'h02, 8'h01, 8'h01);
    chk({sc, sp, lt, fc, cc}, {2'b11, 8'h04, 8'h00, 1'b0});
    chk({lp[55:48], lp[2]}, {ESL_REASON_CANRQ, 1'b1});
    send(8'h05, 8'h00, 8'h01);
    chk(lt, 8'h24);
    send(8'h02, 8'h00, 8'h00);
    chk({sl, lt}, {1'b1, 8'h20});
    send(8'h05, 8'h00, 8'h00);
    send(8'h03, 8'h00, 8'hFF);
    chk({sl, lt, sp}, {1'b0, 8'h00, 1'b1});
    rsn = 8'h05;
    rsv = 1;
    @(negedge mclk_i);
    rsv = 0;
    chk(lp[55:48], 8'h05);
    rsn = 8'h1C;
    rsv = 1;
    @(negedge mclk_i);
    rsv = 0;
    chk(lp[55:48], 8'h00);
    ign = 0;
    repeat (2) @(negedge mclk_i);
    ign = 1;
    repeat (2) @(negedge mclk_i);
    chk(sc, 1'b1);
    ard = 1;
    @(negedge mclk_i);
    chk(sc, 1'b1);
    ign = 0;
    repeat (2) @(negedge mclk_i);
    chk({sc, sp}, 2'b00);
    oth = 1;
    own = 0;
    send(8'h04, 8'h00, 8'h01);
    send(8'h04, 8'h00, 8'h00);
    chk({lt, fc, cc, lp[2]}, {8'h00, 8'h00, 1'b1, 1'b1});
    oth = 0;
    own = 1;
    @(negedge mclk_i);
    chk({fc, cc}, {8'h40, 1'b1});
    ign = 1;
    ard = 0;
    send(8'h01, 8'h01, 8'h01);
    chk({sc, lt}, {1'b1, 8'h02});
    sys_rst_i = 1;
    @(negedge mclk_i);
    chk({sc, sp, sl, lt, fc, cc}, 20'h00000);
    chk(lp | ip, 64'h0);
    sys_rst_i = 0;
    repeat (2) @(negedge mclk_i);
    chk({sc, lt, fc}, {1'b0, 8'h00, 8'h40});
    summarize();
  end
endmodule : engine_stop_limit_status_msgs_test
`default_nettype wire

// ---- bench/esl_core_chk.sv ----
/* port checker for the stop and limitation block; bound to esl_core */
`timescale 1ns/10ps
`default_nettype none
module esl_core_chk
(
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_src_addr_i,
  input  wire logic [63:0] rx_data_i,
  input  wire logic        engine_running_i,
  input  wire logic        ignition_on_i,
  input  wire logic        afterrun_done_i,
  input  wire logic        starter_owned_i,
  input  wire logic [3:0]  lim2_active_i,
  input  wire logic [7:0]  torque_map_i,
  input  wire logic [7:0]  din1_i,
  input  wire logic [4:0]  din2_i,
  input  wire logic        stop_cmd_o,
  input  wire logic        start_prevent_o,
  input  wire logic        start_lock_o,
  input  wire logic [7:0]  lock_table_o,
  input  wire logic [7:0]  fuel_cmd_o,
  input  wire logic        crank_cmd_o,
  input  wire logic [63:0] lim_payload_o,
  input  wire logic [63:0] inp_payload_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_stop_raise: assert property (rx_valid_i && rx_data_i[7:0] == 8'h01 |=> stop_cmd_o)
    else $error("stop not raised");
  a_prevent_enter: assert property (rx_valid_i && rx_data_i[7:0] == 8'h01
    && !engine_running_i |=> start_prevent_o) else $error("no start prevention");
  a_stop_latched: assert property (stop_cmd_o && (ignition_on_i || !afterrun_done_i)
    |=> stop_cmd_o) else $error("stop dropped");
  a_lock_record: assert property (rx_valid_i && rx_data_i[15:8] == 8'h01
    |=> lock_table_o[$past(rx_src_addr_i[2:0])]) else $error("lock not kept");
  a_lock_release: assert property (rx_valid_i && rx_data_i[15:8] == 8'h00
    |=> !lock_table_o[$past(rx_src_addr_i[2:0])]) else $error("lock not released");
  a_fuel_zero: assert property (start_prevent_o || start_lock_o |-> fuel_cmd_o == 8'h00)
    else $error("fuel during prevention");
  a_crank_block: assert property (start_prevent_o && $past(starter_owned_i) |-> !crank_cmd_o)
    else $error("cranking during prevention");
  a_lim2_layout: assert property (!$past(sys_rst_i) |-> lim_payload_o[15:8]
    == {2'h0, $past(lim2_active_i), 2'h0}) else $error("limitation byte 2");
  a_map_code: assert property (!$past(sys_rst_i) && $past(torque_map_i) <= 8'h07
    |-> lim_payload_o[23:16] == $past(torque_map_i)) else $error("torque map code");
  a_reason_canrq: assert property (rx_valid_i && rx_data_i[7:0] == 8'h01
    |=> lim_payload_o[55:48] == 8'h03) else $error("stop reason code");
  a_pins_raw: assert property (!$past(sys_rst_i) |-> inp_payload_o[12:0]
    == {$past(din2_i), $past(din1_i)}) else $error("pin levels");
endmodule : esl_core_chk
bind esl_core esl_core_chk u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .rx_valid_i(rx_valid_i), .engine_running_i(engine_running_i), .ignition_on_i(ignition_on_i),
  .afterrun_done_i(afterrun_done_i), .starter_owned_i(starter_owned_i),
  .rx_src_addr_i(rx_src_addr_i), .torque_map_i(torque_map_i), .din1_i(din1_i),
  .lock_table_o(lock_table_o), .fuel_cmd_o(fuel_cmd_o), .rx_data_i(rx_data_i),
  .lim_payload_o(lim_payload_o), .inp_payload_o(inp_payload_o), .lim2_active_i(lim2_active_i),
  .din2_i(din2_i), .stop_cmd_o(stop_cmd_o), .start_prevent_o(start_prevent_o),
  .start_lock_o(start_lock_o), .crank_cmd_o(crank_cmd_o));
`default_nettype wire

// ---- bench/esl_node.sv ----
/* far-side node sending stop request payloads; assumes one clock */
`timescale 1ns/10ps
`default_nettype none
module esl_node
(
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [7:0]  src_i,
  input  wire logic [7:0]  stop_i,
  input  wire logic [7:0]  lock_i,
  output logic             valid_o,
  output logic [7:0]       src_o,
  output logic [63:0]      data_o
);
  // one frame per go cycle, idle bus shows the inverse pattern
  always @(posedge clk_i)
  begin
    valid_o <= go_i;
    src_o   <= go_i ? src_i : ~src_o;
    data_o  <= go_i ? {48'hFFFFFFFFFFFF, lock_i, stop_i} : ~data_o;
  end
endmodule : esl_node
`default_nettype wire

// ---- rtl/esl_core.sv ----
/*
  Engine stop request decoder with per-sender start lock table, limitation
  status payload encoder and input state payload encoder.
  Assumes one clock, payloads and strobes synchronous to it, and that the
  outside logic supplies engine state, ignition, after-run end and all
  limitation sources already evaluated.
*/
`timescale 1ns/10ps
`default_nettype none
module esl_core
  import esl_pkg::*;
#(
  parameter int NODES     = ESL_NODES,
  parameter int NODE_BITS = ESL_NODE_BITS
)
(
  input  wire logic                 mclk_i,
  input  wire logic                 sys_rst_i,
  // received stop request
  input  wire logic                 rx_valid_i,
  input  wire logic [7:0]           rx_src_addr_i,
  input  wire logic [63:0]          rx_data_i,
  // engine context
  input  wire logic                 engine_running_i,
  input  wire logic                 ignition_on_i,
  input  wire logic                 afterrun_done_i,
  input  wire logic                 starter_owned_i,
  input  wire logic                 other_lock_i,
  input  wire logic [7:0]           fuel_demand_i,
  input  wire logic                 crank_demand_i,
  // limitation sources
  input  wire logic [7:0]           lim1_active_i,
  input  wire logic [7:0]           lim1_armed_i,
  input  wire logic [3:0]           lim2_active_i,
  input  wire logic [7:0]           torque_map_i,
  input  wire logic [7:0]           speed_src_i,
  input  wire logic [7:0]           torque_src_i,
  input  wire logic [7:0]           power_src_i,
  input  wire logic [7:0]           stop_reason_i,
  input  wire logic                 stop_reason_valid_i,
  // input pins and converted values
  input  wire logic [7:0]           din1_i,
  input  wire logic [4:0]           din2_i,
  input  wire logic                 ain3_present_i,
  input  wire logic [3:0][15:0]     ain_mv_i,
  input  wire logic [15:0]          pulse_rpm_i,
  // outputs
  output logic                      stop_cmd_o,
  output logic                      start_prevent_o,
  output logic                      start_lock_o,
  output logic [NODES-1:0]          lock_table_o,
  output logic [7:0]                fuel_cmd_o,
  output logic                      crank_cmd_o,
  output logic [63:0]               lim_payload_o,
  output logic [63:0]               inp_payload_o
);

  typedef struct packed {
    esl_pwr_t         pwr;
    logic             stop;
    logic             prevent;
    logic [NODES-1:0] locks;
    logic [7:0]       reason;
    logic [7:0]       fuel;
    logic             crank;
    logic [63:0]      lim;
    logic [63:0]      inp;
  } esl_state_t;

  esl_state_t st;
  esl_state_t next_st;

  // reset image: power tracker idle, every latch and payload clear
  localparam esl_state_t ESL_ST_RST = '{pwr: ESL_IDLE, default: '0};

  // millivolts to 0.05 V counts, clamped to a byte
  function automatic logic [7:0] esl_volt(input logic [15:0] mv);
    logic [15:0] q;
    q = 16'(mv / 16'(ESL_MV_PER_LSB));
    if (q > 16'h00FF)
      esl_volt = ESL_UNDEF;
    else
      esl_volt = q[7:0];
  endfunction : esl_volt

  // clamp a code to its range, out of range reads as zero
  function automatic logic [7:0] esl_code(input logic [7:0] c, input logic [7:0] mx);
    esl_code = (c > mx) ? 8'h00 : c;
  endfunction : esl_code

  logic [7:0]           b1;
  logic [7:0]           b2;
  logic [NODE_BITS-1:0] slot;
  logic [15:0]          spd;
  logic                 stop_rx;
  logic                 release_ok;

  assign b1      = rx_data_i[7:0];
  assign b2      = rx_data_i[15:8];
  assign slot    = rx_src_addr_i[NODE_BITS-1:0];
  // a stop demand counts from any sender, a single frame is enough
  assign stop_rx = rx_valid_i && (b1 == ESL_STOP_VAL);

  // decode, latch and encode in one next-state pass
  always_comb
  begin
    next_st    = st;
    release_ok = 1'b0;
    spd        = 16'(pulse_rpm_i / 16'(ESL_RPM_PER_LSB));
    // power cycle tracker: the latch may only drop once the after-run ends with
    // ignition still off; switching on again before that keeps the demand
    case (st.pwr)
      ESL_IDLE:
      begin
        if (ignition_on_i)
          next_st.pwr = ESL_RUN;
      end
      ESL_RUN:
      begin
        if (!ignition_on_i)
          next_st.pwr = ESL_OFF;
      end
      ESL_OFF:
      begin
        if (ignition_on_i)
          next_st.pwr = ESL_RUN;
        else if (afterrun_done_i)
        begin
          next_st.pwr = ESL_IDLE;
          release_ok  = 1'b1;
        end
      end
      default:
        next_st.pwr = ESL_IDLE;
    endcase
    // stop demand and reason
    if (stop_rx)
    begin
      next_st.stop   = 1'b1;
      next_st.reason = ESL_REASON_CANRQ;
      if (!engine_running_i)
        next_st.prevent = 1'b1;
    end
    // per-sender start lock table
    if (rx_valid_i)
    begin
      if (b2 == ESL_LOCK_SET)
        next_st.locks[slot] = 1'b1;
      else if (b2 == ESL_LOCK_REL)
        next_st.locks[slot] = 1'b0;
    end
    if (stop_reason_valid_i && !stop_rx)
      next_st.reason = esl_code(stop_reason_i, ESL_REASON_MAX);
    // a new demand in the release cycle wins over the release
    if (release_ok && !stop_rx)
    begin
      next_st.stop    = 1'b0;
      next_st.prevent = 1'b0;
    end
    // actuators during start prevention
    if (next_st.prevent || next_st.stop || (|next_st.locks) || other_lock_i)
    begin
      next_st.fuel  = 8'h00;
      next_st.crank = starter_owned_i ? 1'b0 : crank_demand_i;
    end
    else
    begin
      next_st.fuel  = fuel_demand_i;
      next_st.crank = crank_demand_i;
    end
    // limitation payload
    next_st.lim[7:0]   = lim1_active_i & lim1_armed_i;
    next_st.lim[2]     = (lim1_active_i[2] & lim1_armed_i[2]) | next_st.prevent
                         | (|next_st.locks) | other_lock_i;
    next_st.lim[15:8]  = {2'b00, lim2_active_i, 2'b00};
    next_st.lim[23:16] = esl_code(torque_map_i, ESL_MAP_MAX);
    next_st.lim[31:24] = esl_code(speed_src_i, ESL_SPD_MAX);
    next_st.lim[39:32] = esl_code(torque_src_i, ESL_TRQ_MAX);
    next_st.lim[47:40] = esl_code(power_src_i, ESL_PWR_MAX);
    next_st.lim[55:48] = next_st.reason;
    next_st.lim[63:56] = ESL_UNDEF;
    // input state payload
    next_st.inp[7:0]   = din1_i;
    next_st.inp[15:8]  = {3'b000, din2_i};
    next_st.inp[23:16] = ain3_present_i ? esl_volt(ain_mv_i[0]) : ESL_UNDEF;
    next_st.inp[31:24] = esl_volt(ain_mv_i[1]);
    next_st.inp[39:32] = esl_volt(ain_mv_i[2]);
    next_st.inp[47:40] = esl_volt(ain_mv_i[3]);
    next_st.inp[63:48] = spd;                                   // low byte in byte 7
  end

  // state register
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st <= ESL_ST_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign stop_cmd_o      = st.stop;
  assign start_prevent_o = st.prevent;
  assign start_lock_o    = |st.locks;
  assign lock_table_o    = st.locks;
  assign fuel_cmd_o      = st.fuel;
  assign crank_cmd_o     = st.crank;
  assign lim_payload_o   = st.lim;
  assign inp_payload_o   = st.inp;

endmodule : esl_core
`default_nettype wire

// ---- rtl/esl_pkg.sv ----
/*
  Constants for the engine stop, limitation status and input state payload block.
  Assumes a CAN controller outside that delivers whole 8-byte payloads with the
  sender's source address, and takes whole payloads for transmission.
*/
// Operation
// - byte 1 stop value raises stop command
// - stop demand accepted from any sender
// - demand while stopped enters start prevention
// - demand latched until ignition-off after-run ends
// - lock byte: 00 release, 01 lock, FF none
// - lock held until every locking sender releases
// - release clears only this message's lock
// - prevention zeroes fuel, inhibits owned starter
// - limitation byte 1 from eight flags
// - flags set only while actually limiting
// - limitation byte 2 bits 5..2, rest zero
// - byte 3 reports selected torque curve code
// - byte 4 lowest engine speed limit code
// - byte 5 lowest torque limit code
// - byte 6 strongest power reduction source
// - byte 7 shut-off reason, 3 for request
// - inputs byte 1 raw digital pin levels
// - inputs byte 2 five further pin levels
// - bytes 3-6 analogue at 0.05 V steps
// - bytes 7-8 pulse speed at 5 rpm/count
package esl_pkg;
  localparam logic [7:0] ESL_STOP_VAL     = 8'h01;
  localparam logic [7:0] ESL_LOCK_REL     = 8'h00;
  localparam logic [7:0] ESL_LOCK_SET     = 8'h01;
  localparam logic [7:0] ESL_UNDEF        = 8'hFF;
  localparam logic [7:0] ESL_REASON_CANRQ = 8'h03;
  localparam logic [7:0] ESL_REASON_MAX   = 8'h1B;
  localparam logic [7:0] ESL_MAP_MAX      = 8'h07;
  localparam logic [7:0] ESL_SPD_MAX      = 8'h06;
  localparam logic [7:0] ESL_TRQ_MAX      = 8'h0F;
  localparam logic [7:0] ESL_PWR_MAX      = 8'h14;
  localparam int         ESL_MV_PER_LSB   = 50;
  localparam int         ESL_RPM_PER_LSB  = 5;
  localparam int         ESL_NODES        = 8;
  localparam int         ESL_NODE_BITS    = 3;
  typedef enum logic [2:0] {
    ESL_IDLE = 3'h1,
    ESL_RUN  = 3'h2,
    ESL_OFF  = 3'h4
  } esl_pwr_t;
endpackage : esl_pkg
